//--- rtl/map_params.svh
`ifndef MAP_PARAMS_SVH
`define MAP_PARAMS_SVH
// time figures in nanoseconds, the overhead in microseconds
`define MAP_CLK_PERIOD_NS 10
`define MAP_MIN_DELAY_NS 200
`define MAP_DELAY_UNCERT_NS 100
`define MAP_OVERHEAD_US 140
`define MAP_NS_PER_US 1000
`define MAP_DELAY_W 24
`define MAP_TIME_W 32
`endif

//--- rtl/map_pkg.sv
package map_pkg;
  // measurement control state
  typedef enum logic [2:0] {
    MAP_IDLE, MAP_DELAY, MAP_WAIT_TRIG, MAP_MEASURE, MAP_HOLD
  } map_state_t;
  // configuration set by the controller
  typedef struct packed {
    logic enable;
    logic arm_enable;
    logic common_input_routing;
    logic single_mode;
    logic [23:0] arm_delay;
    logic [31:0] meas_time;
  } map_cfg_t;
  // status shown outside
  typedef struct packed {
    logic busy;
    logic armed;
    logic measuring;
    logic holding;
  } map_status_t;
endpackage : map_pkg

//--- rtl/map_edge_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser with rising edge pulse from the second stage
module map_edge_sync (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic rise
);
  logic meta;
  logic sync;
  logic sync_d;

  // first stage is read only by the second
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b0;
      sync <= 1'b0;
      sync_d <= 1'b0;
    end else begin
      meta <= async_in;
      sync <= meta;
      sync_d <= sync;
    end
  end

  // edge register keeps the output straight from a flop
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rise <= 1'b0;
    end else begin
      rise <= sync & ~sync_d;
    end
  end
endmodule : map_edge_sync

//--- rtl/map_arm_pace.sv
`timescale 1ns/1ps
`include "map_params.svh"

module map_arm_pace
  import map_pkg::*;
#(
  parameter int CLK_NS = `MAP_CLK_PERIOD_NS,
  parameter int OVERHEAD_CYC = (`MAP_OVERHEAD_US * `MAP_NS_PER_US) / `MAP_CLK_PERIOD_NS
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire map_cfg_t cfg,
  input wire logic ext_arm,
  input wire logic meas_sig,
  input wire logic prescaler_go,
  input wire logic prescaler_in,
  output logic gated_count,
  output logic meas_start,
  output logic meas_gate,
  output map_status_t status
);
  localparam int MIN_DELAY_CYC = (`MAP_MIN_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int UNCERT_CYC = `MAP_DELAY_UNCERT_NS / CLK_NS;

  initial begin
    if (CLK_NS < 1 || UNCERT_CYC < 1 || OVERHEAD_CYC < 1) begin
      $error("map_arm_pace: clock period unsupported");
    end
  end

  logic ext_rise;
  logic sig_rise;
  logic go_s0;
  logic go_s1;
  logic arm_event;
  logic [`MAP_DELAY_W-1:0] delay_cnt;
  logic [`MAP_DELAY_W-1:0] delay_load;
  logic [`MAP_TIME_W-1:0] time_cnt;
  logic [`MAP_TIME_W-1:0] hold_load;
  logic [`MAP_DELAY_W-1:0] dly_seen;
  map_state_t state;

  map_edge_sync u_ext (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(ext_arm),
    .rise(ext_rise)
  );
  map_edge_sync u_sig (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(meas_sig),
    .rise(sig_rise)
  );

  // go detector level passes two flops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      go_s0 <= 1'b0;
      go_s1 <= 1'b0;
    end else begin
      go_s0 <= prescaler_go;
      go_s1 <= go_s1 ^ (go_s0 ^ go_s1);
    end
  end

  // arming source: external sync or measured signal via common routing
  assign arm_event = cfg.common_input_routing ? sig_rise : ext_rise;

  // delay clamp; one cycle resolution is well inside the placement bound
  assign delay_load = (cfg.arm_delay < `MAP_DELAY_W'(MIN_DELAY_CYC)) ?
                      `MAP_DELAY_W'(MIN_DELAY_CYC) : cfg.arm_delay;

  // single mode holds for the set time, free run adds overhead
  assign hold_load = cfg.single_mode ? cfg.meas_time :
                     (cfg.meas_time + `MAP_TIME_W'(OVERHEAD_CYC));

  // main sequencer; arming in busy states falls through unused
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= MAP_IDLE;
      delay_cnt <= '0;
    end else begin
      unique case (state)
        MAP_IDLE: begin
          if (cfg.enable) begin
            if (!cfg.arm_enable) begin
              state <= MAP_WAIT_TRIG;
            end else if (arm_event) begin
              state <= MAP_DELAY;
              delay_cnt <= delay_load;
            end
          end
        end
        MAP_DELAY: begin
          if (delay_cnt <= `MAP_DELAY_W'(1)) begin
            state <= MAP_WAIT_TRIG;
          end else begin
            delay_cnt <= delay_cnt - `MAP_DELAY_W'(1);
          end
        end
        MAP_WAIT_TRIG: begin
          if (!cfg.enable) begin
            state <= MAP_IDLE;
          end else if (sig_rise) begin
            state <= MAP_MEASURE;
          end
        end
        MAP_MEASURE: begin
          if (time_cnt <= `MAP_TIME_W'(1)) begin
            state <= MAP_HOLD;
          end
        end
        MAP_HOLD: begin
          if (time_cnt <= `MAP_TIME_W'(1)) begin
            state <= MAP_IDLE;
          end
        end
      endcase
    end
  end

  // measurement and hold timer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      time_cnt <= '0;
    end else if (state == MAP_WAIT_TRIG && sig_rise && cfg.enable) begin
      time_cnt <= cfg.meas_time;
    end else if (state == MAP_MEASURE && time_cnt <= `MAP_TIME_W'(1)) begin
      time_cnt <= hold_load;
    end else if (time_cnt != '0) begin
      time_cnt <= time_cnt - `MAP_TIME_W'(1);
    end
  end

  // start pulse, gate and go gating outputs
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meas_start <= 1'b0;
      meas_gate <= 1'b0;
      gated_count <= 1'b0;
    end else begin
      meas_start <= (state == MAP_WAIT_TRIG) && sig_rise && cfg.enable;
      meas_gate <= (state == MAP_MEASURE);
      gated_count <= prescaler_in & (go_s1 | cfg.arm_enable);
    end
  end

  // status flags
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= '0;
    end else begin
      status.busy <= (state != MAP_IDLE);
      status.armed <= (state == MAP_WAIT_TRIG);
      status.measuring <= (state == MAP_MEASURE);
      status.holding <= (state == MAP_HOLD);
    end
  end

  // cycles already spent in the delay state; a counter keeps the
  // minimum delay check cheap instead of a long repetition
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dly_seen <= '0;
    end else if (state == MAP_DELAY) begin
      dly_seen <= dly_seen + `MAP_DELAY_W'(1);
    end else begin
      dly_seen <= '0;
    end
  end

  // checks
  property p_start_needs_trig;
    @(posedge ref_clk) disable iff (!rst_n)
      meas_start |-> $past(state) == MAP_WAIT_TRIG && $past(sig_rise);
  endproperty
  a_start_needs_trig: assert property (p_start_needs_trig)
    else $error("start without trigger");

  property p_unarmed_wait;
    @(posedge ref_clk) disable iff (!rst_n)
      (state == MAP_IDLE && cfg.enable && !cfg.arm_enable) |=> state == MAP_WAIT_TRIG;
  endproperty
  a_unarmed_wait: assert property (p_unarmed_wait)
    else $error("unarmed did not wait for trigger");

  property p_go_block;
    @(posedge ref_clk) disable iff (!rst_n)
      (!go_s1 && !cfg.arm_enable) |=> !gated_count;
  endproperty
  a_go_block: assert property (p_go_block)
    else $error("prescaler passed without go");

  property p_go_bypass;
    @(posedge ref_clk) disable iff (!rst_n)
      (cfg.arm_enable && prescaler_in) |=> gated_count;
  endproperty
  a_go_bypass: assert property (p_go_bypass)
    else $error("arming did not bypass go gate");

  property p_min_delay;
    @(posedge ref_clk) disable iff (!rst_n)
      (state == MAP_DELAY && delay_cnt <= `MAP_DELAY_W'(1)) |->
        dly_seen >= MIN_DELAY_CYC - 1;
  endproperty
  a_min_delay: assert property (p_min_delay)
    else $error("arming delay too short");

  property p_delay_exit;
    @(posedge ref_clk) disable iff (!rst_n)
      (state == MAP_DELAY && delay_cnt <= `MAP_DELAY_W'(1)) |=> state == MAP_WAIT_TRIG;
  endproperty
  a_delay_exit: assert property (p_delay_exit)
    else $error("delay expiry late");

  property p_hold_load;
    @(posedge ref_clk) disable iff (!rst_n)
      (state == MAP_MEASURE && time_cnt <= `MAP_TIME_W'(1)) |=>
        time_cnt == $past(hold_load) && state == MAP_HOLD;
  endproperty
  a_hold_load: assert property (p_hold_load)
    else $error("hold period wrong");

  property p_overhead;
    @(posedge ref_clk) disable iff (!rst_n)
      !cfg.single_mode |-> hold_load == cfg.meas_time + `MAP_TIME_W'(OVERHEAD_CYC);
  endproperty
  a_overhead: assert property (p_overhead)
    else $error("free run overhead missing");

  property p_ignore_busy;
    @(posedge ref_clk) disable iff (!rst_n)
      (state == MAP_HOLD && time_cnt > `MAP_TIME_W'(1)) |=> state == MAP_HOLD;
  endproperty
  a_ignore_busy: assert property (p_ignore_busy)
    else $error("arming accepted while busy");

  property p_start_once;
    @(posedge ref_clk) disable iff (!rst_n)
      meas_start |=> !meas_start;
  endproperty
  a_start_once: assert property (p_start_once)
    else $error("start pulse longer than one cycle");

  property p_gate_follow;
    @(posedge ref_clk) disable iff (!rst_n)
      (state == MAP_MEASURE) |=> meas_gate;
  endproperty
  a_gate_follow: assert property (p_gate_follow)
    else $error("gate missing during measurement");

  property p_delay_load;
    @(posedge ref_clk) disable iff (!rst_n)
      (state == MAP_IDLE && cfg.enable && cfg.arm_enable && arm_event) |=>
        state == MAP_DELAY && delay_cnt == $past(delay_load);
  endproperty
  a_delay_load: assert property (p_delay_load)
    else $error("arming pulse not taken");

  property p_common_src;
    @(posedge ref_clk) disable iff (!rst_n)
      (cfg.common_input_routing && cfg.enable && cfg.arm_enable &&
       state == MAP_IDLE && sig_rise) |=> state == MAP_DELAY;
  endproperty
  a_common_src: assert property (p_common_src)
    else $error("measured input did not arm");

  property p_delay_ignore;
    @(posedge ref_clk) disable iff (!rst_n)
      (state == MAP_DELAY && delay_cnt > `MAP_DELAY_W'(1)) |=> state == MAP_DELAY;
  endproperty
  a_delay_ignore: assert property (p_delay_ignore)
    else $error("delay cut short");

  property p_measure_len;
    @(posedge ref_clk) disable iff (!rst_n)
      (state == MAP_MEASURE && time_cnt > `MAP_TIME_W'(1)) |=> state == MAP_MEASURE;
  endproperty
  a_measure_len: assert property (p_measure_len)
    else $error("measurement ended early");

  property p_enable_drop;
    @(posedge ref_clk) disable iff (!rst_n)
      (state == MAP_WAIT_TRIG && !cfg.enable) |=> state == MAP_IDLE;
  endproperty
  a_enable_drop: assert property (p_enable_drop)
    else $error("disable did not return to idle");

  property p_status_busy;
    @(posedge ref_clk) disable iff (!rst_n)
      (state != MAP_IDLE) |=> status.busy;
  endproperty
  a_status_busy: assert property (p_status_busy)
    else $error("busy flag missing");

  c_free_hold: cover property (@(posedge ref_clk) disable iff (!rst_n)
    !cfg.single_mode && state == MAP_HOLD);
  c_gate_bypass: cover property (@(posedge ref_clk) disable iff (!rst_n)
    cfg.arm_enable && prescaler_in && !go_s1);
  c_armed_start: cover property (@(posedge ref_clk) disable iff (!rst_n)
    state == MAP_DELAY ##[1:1000] meas_start);
  c_common: cover property (@(posedge ref_clk) disable iff (!rst_n)
    cfg.common_input_routing && state == MAP_DELAY);
  c_hold_done: cover property (@(posedge ref_clk) disable iff (!rst_n)
    state == MAP_HOLD ##1 state == MAP_IDLE);
endmodule : map_arm_pace

//--- dv/map_far_model.sv
`timescale 1ns/1ps
// sync source and measured input; both lines rest low between bursts
module map_far_model (
  input wire logic ref_clk,
  input wire logic sig_run,
  output logic ext_arm,
  output logic meas_sig
);
  logic [1:0] phase = 2'h0;
  initial begin
    ext_arm = 1'b0;
    meas_sig = 1'b0;
  end
  // square wave, six cycles a period, still when the burst is off
  always @(posedge ref_clk) begin
    phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
    if (phase == 2'h2) meas_sig <= #1 sig_run & ~meas_sig;
  end
  // one external sync pulse, long enough for the synchroniser
  task arm_pulse();
    @(posedge ref_clk);
    #1 ext_arm = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 ext_arm = 1'b0;
  endtask : arm_pulse
endmodule : map_far_model

//--- dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  import map_pkg::*;
  localparam int OVH = 10;
  localparam int T = 16;
  logic ref_clk, rst_n, prescaler_go, prescaler_in, sig_run;
  logic gated_count, meas_start, meas_gate, ext_arm, meas_sig;
  map_cfg_t cfg;
  map_status_t status;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int n;
  map_arm_pace #(.OVERHEAD_CYC(OVH)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .cfg(cfg),
    .ext_arm(ext_arm), .meas_sig(meas_sig), .prescaler_go(prescaler_go),
    .prescaler_in(prescaler_in), .gated_count(gated_count), .meas_start(meas_start),
    .meas_gate(meas_gate), .status(status));
  map_far_model far (.ref_clk(ref_clk), .sig_run(sig_run), .ext_arm(ext_arm),
    .meas_sig(meas_sig));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // hang guard, far above the under two thousand cycles the run needs
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task step(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : step
  // cycles until meas_start, lim when it never comes
  task wait_start(input int lim, output int k);
    k = 0;
    while (meas_start !== 1'b1 && k < lim) begin
      step(1);
      k++;
    end
  endtask : wait_start
  task next_start(output int k);
    step(1);
    wait_start(300, k);
    k++;
  endtask : next_start
  task s_gate();
    prescaler_in = 1'b1;
    step(5);
    check("gate blocked", gated_count, 1'b0);
    prescaler_go = 1'b1;
    step(6);
    check("gate open", gated_count, 1'b1);
    prescaler_go = 1'b0;
    cfg.arm_enable = 1'b1;
    step(6);
    check("gate armed", gated_count, 1'b1);
    cfg.arm_enable = 1'b0;
  endtask : s_gate
  task s_pace();
    cfg.meas_time = T;
    cfg.single_mode = 1'b1;
    step(20);
    check("no start idle", status.measuring, 1'b0);
    check("waiting armed", status.armed, 1'b1);
    sig_run = 1'b1;
    wait_start(40, n);
    check("burst start", meas_start, 1'b1);
    step(2);
    check("gate level", meas_gate, 1'b1);
    next_start(n);
    check("single pace", n >= 2 * T && n <= 2 * T + 14, 1'b1);
    cfg.single_mode = 1'b0;
    next_start(n);
    next_start(n);
    check("free pace", n >= 2 * T + OVH && n <= 2 * T + OVH + 14, 1'b1);
  endtask : s_pace
  task s_armed();
    cfg.arm_enable = 1'b1;
    cfg.single_mode = 1'b1;
    cfg.arm_delay = 24'h5;
    cfg.meas_time = 32'h28;
    step(200);
    check("unarmed idle", status.measuring, 1'b0);
    far.arm_pulse();
    wait_start(60, n);
    check("clamped delay", n >= 20 && n <= 40, 1'b1);
    far.arm_pulse();
    wait_start(200, n);
    check("arm in cycle", n, 200);
    far.arm_pulse();
    wait_start(60, n);
    check("arm paces", meas_start, 1'b1);
  endtask : s_armed
  task s_common();
    step(200);
    cfg.common_input_routing = 1'b1;
    cfg.arm_delay = 24'h1e;
    wait_start(150, n);
    check("common arm", meas_start, 1'b1);
  endtask : s_common
  task complete_run();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  initial begin
    rst_n = 1'b0;
    cfg = '0;
    prescaler_go = 1'b0;
    prescaler_in = 1'b0;
    sig_run = 1'b0;
    step(20);
    rst_n = 1'b1;
    cfg.enable = 1'b1;
    step(2);
    s_gate();
    s_pace();
    s_armed();
    s_common();
    complete_run();
  end
endmodule : testbench
